// ### logic/cmpev_consts.svh
`ifndef CMPEV_CONSTS_SVH
`define CMPEV_CONSTS_SVH

// reset values of control and status state
`define CMPEV_RST_SYNC_LATCH 1'h0
`define CMPEV_RST_PREV_LEVEL 1'h0
`define CMPEV_RST_IRQ_FLAG 1'h0
`define CMPEV_RST_TCLK_PREV 1'h0
`define CMPEV_RST_OUT 1'h0

// field positions inside the control struct image
`define CMPEV_BIT_ON 0
`define CMPEV_BIT_INVERT 1
`define CMPEV_BIT_HYS 2
`define CMPEV_BIT_SYNC 3

`endif

// ### logic/cmpev_edge_det.sv
`include "cmpev_consts.svh"

module cmpev_edge_det (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic level,
  output cmpev_pkg::cmpev_edge_e edge_kind
);

  logic prev_r;
  logic prev_nxt;

  always_comb begin
    prev_nxt = level;
    case ({prev_r, level})
      2'h1: edge_kind = cmpev_pkg::CMPEV_EDGE_RISE;
      2'h2: edge_kind = cmpev_pkg::CMPEV_EDGE_FALL;
      default: edge_kind = cmpev_pkg::CMPEV_EDGE_NONE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prev_r <= `CMPEV_RST_PREV_LEVEL;
    end else begin
      prev_r <= prev_nxt;
    end
  end

endmodule

// ### logic/cmpev_pkg.sv
package cmpev_pkg;

  // control bits of the first comparator control register
  typedef struct packed {
    logic sync_to_timer_select;
    logic hysteresis_select;
    logic output_invert;
    logic comparator_on;
  } cmpev_ctrl0_s;

  // edge enables of the second comparator control register
  typedef struct packed {
    logic falling_edge_irq_enable;
    logic rising_edge_irq_enable;
  } cmpev_ctrl1_s;

  typedef enum logic [1:0] {
    CMPEV_EDGE_NONE = 2'h0,
    CMPEV_EDGE_RISE = 2'h1,
    CMPEV_EDGE_FALL = 2'h2
  } cmpev_edge_e;

endpackage

// ### logic/cmpev_sync_latch.sv
`include "cmpev_consts.svh"

module cmpev_sync_latch (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic timer_clk_prescaled,
  input wire logic level,
  output logic latched,
  output logic fall_pulse
);

  logic tclk_prev_r;
  logic tclk_prev_nxt;
  logic latch_r;
  logic latch_nxt;

  always_comb begin
    tclk_prev_nxt = timer_clk_prescaled;
    fall_pulse = tclk_prev_r & ~timer_clk_prescaled;
    latch_nxt = latch_r;
    if (fall_pulse) begin
      latch_nxt = level;
    end
    latched = latch_r;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tclk_prev_r <= `CMPEV_RST_TCLK_PREV;
      latch_r <= `CMPEV_RST_SYNC_LATCH;
    end else begin
      tclk_prev_r <= tclk_prev_nxt;
      latch_r <= latch_nxt;
    end
  end

endmodule

// ### logic/cmpev_top.sv
// Behaviour
// - raw result low when positive below negative, high when above
// - hysteresis select bit drives the analog hysteresis control
// - comparator level offered to the timer as a gate source
// - sync select latches output on timer clock falling edge
// - latch clocked by prescaled timer clock when prescaler is used
// - timer counts on rising edge, latch updates on falling edge
// - rising and falling edge detectors on the comparator output
// - enabled rising or falling edge sets the interrupt flag
// - flag held until software clears it
// - edge in the clearing cycle wins, flag stays set
// - edges from polarity or on/off toggles still set the flag
`include "cmpev_consts.svh"

module cmpev_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic analog_decision,
  input wire cmpev_pkg::cmpev_ctrl0_s ctrl0,
  input wire cmpev_pkg::cmpev_ctrl1_s ctrl1,
  input wire logic timer_clk_prescaled,
  input wire logic irq_flag_clear,
  output logic hysteresis_enable,
  output logic comparator_out,
  output logic timer_gate_source,
  output logic comparator_irq_flag,
  output logic rise_seen,
  output logic fall_seen
);

  logic forced_level;
  logic polar_level;
  logic latched_level;
  logic chosen_level;
  cmpev_pkg::cmpev_edge_e edge_kind;

  logic hys_r;
  logic hys_nxt;
  logic out_r;
  logic out_nxt;
  logic gate_r;
  logic gate_nxt;
  logic flag_r;
  logic flag_nxt;
  logic rise_r;
  logic rise_nxt;
  logic fall_r;
  logic fall_nxt;
  logic set_evt;

  // analog core gives high when positive input exceeds negative
  always_comb begin
    forced_level = ctrl0.comparator_on & analog_decision;
    polar_level = forced_level ^ ctrl0.output_invert;
  end

  // latch sampled on falling edge of the prescaled timer clock
  cmpev_sync_latch u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .timer_clk_prescaled(timer_clk_prescaled),
    .level(polar_level),
    .latched(latched_level),
    .fall_pulse()
  );

  always_comb begin
    chosen_level = ctrl0.sync_to_timer_select ? latched_level : polar_level;
  end

  // detection runs whether or not the comparator is on
  cmpev_edge_det u_edge (
    .core_clk(core_clk),
    .nrst(nrst),
    .level(chosen_level),
    .edge_kind(edge_kind)
  );

  // sticky flag: a set in the clearing cycle wins over the clear
  always_comb begin
    set_evt = ((edge_kind == cmpev_pkg::CMPEV_EDGE_RISE) & ctrl1.rising_edge_irq_enable) |
              ((edge_kind == cmpev_pkg::CMPEV_EDGE_FALL) & ctrl1.falling_edge_irq_enable);
    flag_nxt = flag_r;
    if (irq_flag_clear) begin
      flag_nxt = 1'h0;
    end
    if (set_evt) begin
      flag_nxt = 1'h1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      flag_r <= `CMPEV_RST_IRQ_FLAG;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  always_comb begin
    hys_nxt = ctrl0.hysteresis_select;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hys_r <= `CMPEV_RST_OUT;
    end else begin
      hys_r <= hys_nxt;
    end
  end

  // output level and timer gate source carry the same chosen level
  always_comb begin
    out_nxt = chosen_level;
    gate_nxt = chosen_level;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_r <= `CMPEV_RST_OUT;
      gate_r <= `CMPEV_RST_OUT;
    end else begin
      out_r <= out_nxt;
      gate_r <= gate_nxt;
    end
  end

  // edge pulses shown regardless of the edge enables
  always_comb begin
    rise_nxt = (edge_kind == cmpev_pkg::CMPEV_EDGE_RISE);
    fall_nxt = (edge_kind == cmpev_pkg::CMPEV_EDGE_FALL);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rise_r <= `CMPEV_RST_OUT;
      fall_r <= `CMPEV_RST_OUT;
    end else begin
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end

  always_comb begin
    hysteresis_enable = hys_r;
    comparator_out = out_r;
    timer_gate_source = gate_r;
    comparator_irq_flag = flag_r;
    rise_seen = rise_r;
    fall_seen = fall_r;
  end

endmodule

// ### testbench/cmpev_partner.sv
module cmpev_partner (
  input wire logic core_clk,
  input wire logic [7:0] vpos,
  input wire logic [7:0] vneg,
  output logic analog_decision,
  output logic timer_clk_prescaled
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] div_r = 3'h0;
  // ideal core: decision settles at once, no response-time window
  assign analog_decision = vpos > vneg;
  always @(posedge core_clk) div_r <= #1 div_r + 3'h1;
  assign timer_clk_prescaled = div_r[2];
endmodule

// ### testbench/cmpev_props.sv
module cmpev_props (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic analog_decision,
  input wire cmpev_pkg::cmpev_ctrl0_s ctrl0,
  input wire cmpev_pkg::cmpev_ctrl1_s ctrl1,
  input wire logic irq_flag_clear,
  input wire logic timer_clk_prescaled,
  input wire logic hysteresis_enable,
  input wire logic comparator_out,
  input wire logic timer_gate_source,
  input wire logic comparator_irq_flag,
  input wire logic rise_seen,
  input wire logic fall_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic exp_level;
  assign exp_level = ctrl0.output_invert ^ (ctrl0.comparator_on & analog_decision);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_rise; $rose(comparator_out); endsequence
  sequence s_fall; $fell(comparator_out); endsequence
  sequence s_set; rise_seen && $past(ctrl1.rising_edge_irq_enable) || fall_seen && $past(ctrl1.falling_edge_irq_enable); endsequence
  gate_copy_a: assert property (timer_gate_source == comparator_out) else $error("gate differs");
  gate_level_a: assert property ($past(nrst) && !$past(ctrl0.sync_to_timer_select) |->
    timer_gate_source == $past(exp_level)) else $error("gate level wrong");
  hys_follow_a: assert property ($past(nrst) |-> hysteresis_enable == $past(ctrl0.hysteresis_select))
    else $error("hysteresis wrong");
  direct_level_a: assert property ($past(nrst) && !$past(ctrl0.sync_to_timer_select) |->
    comparator_out == $past(exp_level)) else $error("level wrong");
  sync_change_a: assert property ($past(ctrl0.sync_to_timer_select) && $past(ctrl0.sync_to_timer_select, 2) &&
    $changed(comparator_out) |-> $past(timer_clk_prescaled, 3) && !$past(timer_clk_prescaled, 2))
    else $error("synced output moved without timer clock fall");
  rise_pulse_a: assert property (s_rise |-> rise_seen ##1 !rise_seen) else $error("rise missed");
  fall_pulse_a: assert property (s_fall |-> fall_seen ##1 !fall_seen) else $error("fall missed");
  flag_set_a: assert property (s_set |-> comparator_irq_flag) else $error("flag not set");
  flag_hold_a: assert property ($past(comparator_irq_flag) && !$past(irq_flag_clear) |-> comparator_irq_flag)
    else $error("flag dropped");
  flag_cause_a: assert property ($rose(comparator_irq_flag) |-> s_set) else $error("flag without edge");
endmodule

bind cmpev_top cmpev_props i_props (.*);

// ### testbench/comparator_output_event_logic_tb.sv
module comparator_output_event_logic_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'h0, nrst = 1'h0, irq_flag_clear = 1'h0;
  logic analog_decision, timer_clk_prescaled, hysteresis_enable, comparator_out;
  logic timer_gate_source, comparator_irq_flag, rise_seen, fall_seen;
  cmpev_pkg::cmpev_ctrl0_s ctrl0 = 4'h0;
  cmpev_pkg::cmpev_ctrl1_s ctrl1 = 2'h0;
  logic [7:0] vpos = 8'h00, vneg = 8'h00;
  logic [31:0] lfsr = 32'h0C62;
  logic lat, tp, out, prv, rs, fs, flg, hy, lv, fl;
  int n_fail = 0, check_count = 0;
  always #4 core_clk = ~core_clk;
  cmpev_top i_dut (.*);
  cmpev_partner i_far (.*);
  task automatic chk(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic report_and_stop;
    if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) {lat, tp, out, prv, rs, fs, flg, hy} = 8'h00;
    else begin
      lv = ctrl0.output_invert ^ (ctrl0.comparator_on & analog_decision);
      fl = tp & !timer_clk_prescaled;
      tp = timer_clk_prescaled;
      out = ctrl0.sync_to_timer_select ? lat : lv;
      rs = out & !prv;
      fs = !out & prv;
      prv = out;
      if (fl) lat = lv;
      flg = (rs & ctrl1.rising_edge_irq_enable) | (fs & ctrl1.falling_edge_irq_enable) | (flg & !irq_flag_clear);
      hy = ctrl0.hysteresis_select;
    end
  end
  always @(negedge core_clk) begin
    if (nrst) begin
      chk("out", out, comparator_out);
      chk("gate", out, timer_gate_source);
      chk("hys", hy, hysteresis_enable);
      chk("rise", rs, rise_seen);
      chk("fall", fs, fall_seen);
      chk("flag", flg, comparator_irq_flag);
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    #1 nrst = 1'h1;
    for (int i = 0; i < 3000; i++) begin
      @(posedge core_clk);
      #1;
      lfsr = lfsr_next(lfsr);
      vpos = lfsr[7:0];
      vneg = lfsr[15:8];
      // occasional config change toggles on/off, invert and sync too
      if (lfsr[20:18] == 3'h0) ctrl0 = lfsr[27:24];
      ctrl1 = lfsr[29:28];
      irq_flag_clear = lfsr[31] & lfsr[30];
      if (i == 1500) nrst = 1'h0;
      if (i == 1503) nrst = 1'h1;
    end
    report_and_stop();
  end
  initial begin
    #40000;
    n_fail++;
    report_and_stop();
  end
endmodule
